// file: core/addr_retry_n_pkg.sv
// Constants and carrier types for the address-retry and data-grant block.
// Assumes a single synchronous bus clock; all bus controls active low.
package addr_retry_n_pkg;
	localparam logic [1:0] ASSERT_DLY   = 2'h2;
	localparam logic [1:0] NEGATE_DLY   = 2'h1;
	localparam logic [1:0] BR_HOLD_CYC  = 2'h1;
	localparam logic [2:0] BEAT_CNT_W   = 3'h2;
	localparam logic [1:0] BEATS_BURST  = 2'h3;

	typedef enum logic [2:0] {
		RT_IDLE   = 3'h0,
		RT_WAIT   = 3'h1,
		RT_DRIVE  = 3'h2,
		RT_FLOAT  = 3'h3,
		RT_PRECHG = 3'h4
	} retry_e;

	typedef struct packed {
		logic req;
		logic snoop_hit;
		logic need_push;
		logic addr_only;
		logic tenure_open;
	} bus_in_s;

	typedef struct packed {
		retry_e     rt;
		logic [1:0] ts_cnt;
		logic       ts_seen;
		logic       addr_ack_n_d1;
		logic       addr_ack_n_d2;
		logic       push_pend;
		logic [1:0] br_hold;
		logic       data_pend;
		logic       data_own;
		logic [1:0] beat;
		logic       wr_order;
		logic       addr_retry_n_o;
		logic       addr_retry_n_oe;
		logic       br_o;
		logic       dbb_o;
		logic       dbb_oe;
		logic       abort_o;
		logic       retry_o;
	} state_s;
endpackage : addr_retry_n_pkg

// file: core/address_retry_data_grant.sv
// Address-retry drive and sampling, request withdrawal and data grant qualification.
// Assumes a synchronous bus clock; the board resolves the shared retry and busy wires.
// Overview of operation
// - Drive retry low when snoop needs retry
// - Request bus two cycles after acknowledge for push
// - Float retry when no retry needed
// - Retry asserted third cycle after start
// - Begin negating second cycle after acknowledge
// - Float, drive high one cycle, float
// - Precharge disable skips driven-high step
// - Master retried: drop request, retry tenure
// - Abort started data tenure immediately
// - Non-master: drop request one cycle
// - Address after retry may differ
// - Start implies data request unless address-only
// - Write reorder input allows writes first
// - Grant qualified by busy, data retry, retry
// - Negated grant holds off data tenures
// - Grant ignored until start seen
// - Sample retry cycle after acknowledge
// - Assert busy cycle after qualified grant
`timescale 1ns/1ps
module address_retry_data_grant (
	input  wire logic             CLK_I,
	input  wire logic             NRST_I,
	input  wire addr_retry_n_pkg::bus_in_s CTRL_I,
	input  wire logic             ADDR_MASTER_I,
	input  wire logic             PRECHARGE_DIS_I,
	input  wire logic             TRANSFER_START_N_I,
	input  wire logic             ADDR_ACK_N_I,
	input  wire logic             ADDR_RETRY_N_I,
	input  wire logic             DATA_GRANT_N_I,
	input  wire logic             DATA_BUSY_N_I,
	input  wire logic             DATA_RETRY_N_I,
	input  wire logic             TRANSFER_ACK_N_I,
	input  wire logic             WRITE_REORDER_N_I,
	output logic                  ADDR_RETRY_N_O,
	output logic                  ADDR_RETRY_OE_O,
	output logic                  BUS_REQUEST_N_O,
	output logic                  DATA_BUSY_N_O,
	output logic                  DATA_BUSY_OE_O,
	output logic                  DATA_ABORT_O,
	output logic                  TENURE_RETRY_O,
	output logic                  WRITE_FIRST_O
);
	addr_retry_n_pkg::state_s s_r;
	addr_retry_n_pkg::state_s s_nxt;
	logic ts;
	logic addr_ack_n;
	logic addr_retry_n_smp;
	logic qual_grant;
	logic push_go;
	logic mst_retry;

	assign ts         = !TRANSFER_START_N_I;
	assign addr_ack_n       = !ADDR_ACK_N_I;
	assign addr_retry_n_smp  = s_r.addr_ack_n_d1 && !ADDR_RETRY_N_I;
	assign qual_grant = !DATA_GRANT_N_I && DATA_BUSY_N_I && DATA_RETRY_N_I && ADDR_RETRY_N_I;
	assign push_go    = s_r.addr_ack_n_d1 && s_r.push_pend && (s_r.rt == addr_retry_n_pkg::RT_DRIVE) && addr_retry_n_smp;
	assign mst_retry  = addr_retry_n_smp && ADDR_MASTER_I;

	always_comb begin
		s_nxt         = s_r;
		s_nxt.addr_ack_n_d1 = addr_ack_n;
		s_nxt.addr_ack_n_d2 = s_r.addr_ack_n_d1;
		s_nxt.abort_o = 1'b0;
		s_nxt.retry_o = 1'b0;
		if (s_r.br_hold != 2'h0) begin
			s_nxt.br_hold = s_r.br_hold - 2'h1;
		end
		case (s_r.rt)
			addr_retry_n_pkg::RT_IDLE: begin
				s_nxt.addr_retry_n_oe = 1'b0;
				if (ts && CTRL_I.snoop_hit) begin
					s_nxt.rt     = addr_retry_n_pkg::RT_WAIT;
					s_nxt.ts_cnt = 2'h0;
					s_nxt.push_pend = CTRL_I.need_push;
				end
			end
			addr_retry_n_pkg::RT_WAIT: begin
				s_nxt.ts_cnt = s_r.ts_cnt + 2'h1;
				if (s_r.ts_cnt == addr_retry_n_pkg::ASSERT_DLY - 2'h1) begin
					s_nxt.rt       = addr_retry_n_pkg::RT_DRIVE;
					s_nxt.addr_retry_n_o  = 1'b0;
					s_nxt.addr_retry_n_oe = 1'b1;
				end
			end
			addr_retry_n_pkg::RT_DRIVE: begin
				if (s_r.addr_ack_n_d1) begin
					s_nxt.rt       = addr_retry_n_pkg::RT_FLOAT;
					s_nxt.addr_retry_n_oe = 1'b0;
				end
			end
			addr_retry_n_pkg::RT_FLOAT: begin
				if (PRECHARGE_DIS_I) begin
					s_nxt.rt = addr_retry_n_pkg::RT_IDLE;
				end else begin
					s_nxt.rt       = addr_retry_n_pkg::RT_PRECHG;
					s_nxt.addr_retry_n_o  = 1'b1;
					s_nxt.addr_retry_n_oe = 1'b1;
				end
			end
			addr_retry_n_pkg::RT_PRECHG: begin
				s_nxt.rt       = addr_retry_n_pkg::RT_IDLE;
				s_nxt.addr_retry_n_oe = 1'b0;
			end
			default: begin
				s_nxt.rt       = addr_retry_n_pkg::RT_IDLE;
				s_nxt.addr_retry_n_oe = 1'b0;
			end
		endcase
		if (ts && !CTRL_I.addr_only) begin
			s_nxt.ts_seen   = 1'b1;
			s_nxt.data_pend = 1'b1;
		end
		if (addr_retry_n_smp) begin
			if (ADDR_MASTER_I) begin
				s_nxt.retry_o = 1'b1;
				s_nxt.data_pend = 1'b0;
				s_nxt.br_hold = addr_retry_n_pkg::BR_HOLD_CYC;
				if (s_r.data_own) begin
					s_nxt.abort_o  = 1'b1;
					s_nxt.data_own = 1'b0;
				end
			end else begin
				s_nxt.br_hold = addr_retry_n_pkg::BR_HOLD_CYC;
			end
		end
		if (s_r.addr_ack_n_d2 && s_r.push_pend && (s_r.rt == addr_retry_n_pkg::RT_FLOAT)) begin
			s_nxt.push_pend = 1'b0;
		end
		if (push_go) begin
			s_nxt.br_o    = 1'b0;
			s_nxt.br_hold = 2'h0;
		end else if (addr_retry_n_smp || (s_nxt.br_hold != 2'h0)) begin
			s_nxt.br_o = 1'b1;
		end else begin
			s_nxt.br_o = !(CTRL_I.req || s_r.push_pend);
		end
		if (s_r.data_own) begin
			if (!TRANSFER_ACK_N_I) begin
				s_nxt.beat = s_r.beat + 2'h1;
				if (s_r.beat == addr_retry_n_pkg::BEATS_BURST || !CTRL_I.tenure_open) begin
					s_nxt.data_own = 1'b0;
				end
			end
		end else if (s_r.ts_seen && s_r.data_pend && qual_grant && !addr_retry_n_smp) begin
			s_nxt.data_own  = 1'b1;
			s_nxt.data_pend = 1'b0;
			s_nxt.ts_seen   = 1'b0;
			s_nxt.beat      = 2'h0;
			s_nxt.wr_order  = !WRITE_REORDER_N_I;
		end
		s_nxt.dbb_o  = !s_nxt.data_own;
		s_nxt.dbb_oe = s_nxt.data_own || s_r.data_own;
	end

	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			s_r          <= '0;
			s_r.rt       <= addr_retry_n_pkg::RT_IDLE;
			s_r.addr_retry_n_o  <= 1'b1;
			s_r.br_o     <= 1'b1;
			s_r.dbb_o    <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ADDR_RETRY_N_O  = s_r.addr_retry_n_o;
	assign ADDR_RETRY_OE_O = s_r.addr_retry_n_oe;
	assign BUS_REQUEST_N_O = s_r.br_o;
	assign DATA_BUSY_N_O   = s_r.dbb_o;
	assign DATA_BUSY_OE_O  = s_r.dbb_oe;
	assign DATA_ABORT_O    = s_r.abort_o;
	assign TENURE_RETRY_O  = s_r.retry_o;
	assign WRITE_FIRST_O   = s_r.wr_order;

	// Retry pin sequence
	sequence snoop_start;
		(s_r.rt == addr_retry_n_pkg::RT_IDLE) && ts && CTRL_I.snoop_hit;
	endsequence

	sequence drv_then_ack;
		(s_r.rt == addr_retry_n_pkg::RT_DRIVE) && s_r.addr_ack_n_d1;
	endsequence

	sequence wait_done;
		(s_r.rt == addr_retry_n_pkg::RT_WAIT) && (s_r.ts_cnt == addr_retry_n_pkg::ASSERT_DLY - 2'h1);
	endsequence

	sequence push_clear;
		s_r.addr_ack_n_d2 && s_r.push_pend && (s_r.rt == addr_retry_n_pkg::RT_FLOAT);
	endsequence

	sequence grant_take;
		!s_r.data_own && s_r.data_pend && s_r.ts_seen && qual_grant && !addr_retry_n_smp;
	endsequence

	a_retry_float_idle: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(s_r.rt == addr_retry_n_pkg::RT_IDLE) |-> !ADDR_RETRY_OE_O)
		else $error("retry driven while idle");

	a_wait_float: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(s_r.rt == addr_retry_n_pkg::RT_WAIT) |-> !ADDR_RETRY_OE_O)
		else $error("retry driven while waiting");

	a_idle_entry: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		snoop_start |=> (s_r.rt == addr_retry_n_pkg::RT_WAIT))
		else $error("snoop retry not started");

	a_retry_assert_time: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		snoop_start |-> ##3 (ADDR_RETRY_OE_O && !ADDR_RETRY_N_O))
		else $error("retry not asserted third cycle");

	a_wait_to_drive: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		wait_done |=> (s_r.rt == addr_retry_n_pkg::RT_DRIVE))
		else $error("retry wait overran");

	a_retry_low_drive: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(s_r.rt == addr_retry_n_pkg::RT_DRIVE) |-> (ADDR_RETRY_OE_O && !ADDR_RETRY_N_O))
		else $error("retry not driven low");

	a_drive_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		((s_r.rt == addr_retry_n_pkg::RT_DRIVE) && !s_r.addr_ack_n_d1) |=> (ADDR_RETRY_OE_O && !ADDR_RETRY_N_O))
		else $error("retry released before acknowledge");

	a_retry_neg_start: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		drv_then_ack |=> (s_r.rt == addr_retry_n_pkg::RT_FLOAT))
		else $error("negation not started");

	a_retry_negate_seq: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		drv_then_ack ##1 !PRECHARGE_DIS_I |-> !ADDR_RETRY_OE_O ##1 (ADDR_RETRY_OE_O && ADDR_RETRY_N_O) ##1 !ADDR_RETRY_OE_O)
		else $error("bad retry negation");

	a_float_gap: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(s_r.rt == addr_retry_n_pkg::RT_FLOAT) |-> !ADDR_RETRY_OE_O)
		else $error("no float before precharge");

	a_precharge_high: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(s_r.rt == addr_retry_n_pkg::RT_PRECHG) |-> (ADDR_RETRY_OE_O && ADDR_RETRY_N_O))
		else $error("precharge not driven high");

	a_precharge_once: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(s_r.rt == addr_retry_n_pkg::RT_PRECHG) |=> !ADDR_RETRY_OE_O)
		else $error("precharge longer than one cycle");

	a_precharge_skip: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		drv_then_ack ##1 PRECHARGE_DIS_I |-> ##1 !ADDR_RETRY_OE_O)
		else $error("precharge not skipped");

	// Request withdrawal and copy-back request
	a_push_request: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		push_go |=> !BUS_REQUEST_N_O)
		else $error("copy-back request missing");

	a_push_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		push_clear |=> !s_r.push_pend)
		else $error("copy-back request stuck");

	a_req_drop: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(addr_retry_n_smp && !push_go) |=> BUS_REQUEST_N_O)
		else $error("request kept on retry");

	a_req_hold_cnt: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(s_r.br_hold != 2'h0) |-> BUS_REQUEST_N_O)
		else $error("request during hold");

	a_nonmaster_noretry: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(addr_retry_n_smp && !ADDR_MASTER_I) |=> !TENURE_RETRY_O)
		else $error("retry flagged while not master");

	a_master_retry: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		mst_retry |=> TENURE_RETRY_O)
		else $error("tenure retry not flagged");

	a_master_pend_clr: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		mst_retry |=> !s_r.data_pend)
		else $error("retried tenure kept data request");

	a_sample_window: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		TENURE_RETRY_O |-> $past(s_r.addr_ack_n_d1))
		else $error("retry sampled outside window");

	// Data tenure abort
	a_abort_data: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(mst_retry && s_r.data_own) |=> (DATA_ABORT_O && DATA_BUSY_N_O))
		else $error("no abort");

	a_abort_source: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		DATA_ABORT_O |-> $past(mst_retry))
		else $error("abort without retry");

	a_abort_needs_own: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		DATA_ABORT_O |-> $past(s_r.data_own))
		else $error("abort without data tenure");

	a_abort_busy: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		DATA_ABORT_O |-> DATA_BUSY_N_O)
		else $error("busy kept after abort");

	// Data grant qualification
	a_addr_only_none: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(ts && CTRL_I.addr_only && !s_r.data_pend) |=> !s_r.data_pend)
		else $error("address-only start requested data");

	a_data_req: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(ts && !CTRL_I.addr_only && s_r.data_own) |=> s_r.ts_seen)
		else $error("start not recorded");

	a_grant_after_ts: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(!s_r.data_own && !s_r.ts_seen) |=> DATA_BUSY_N_O)
		else $error("grant used before start");

	a_grant_qualified: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(!s_r.data_own && !qual_grant) |=> DATA_BUSY_N_O)
		else $error("unqualified grant used");

	a_hold_no_grant: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(!s_r.data_own && DATA_GRANT_N_I) |=> DATA_BUSY_N_O)
		else $error("took bus without grant");

	a_busy_grant: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		grant_take |=> !DATA_BUSY_N_O)
		else $error("busy not claimed");

	a_reorder_capture: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		grant_take |=> (WRITE_FIRST_O != $past(WRITE_REORDER_N_I)))
		else $error("reorder not captured");

	a_busy_enable: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		!DATA_BUSY_N_O |-> DATA_BUSY_OE_O)
		else $error("busy asserted while floating");

	a_busy_keep: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		(s_r.data_own && TRANSFER_ACK_N_I && !mst_retry) |=> !DATA_BUSY_N_O)
		else $error("busy dropped mid tenure");

	a_busy_release: assert property (@(posedge CLK_I) disable iff (!NRST_I)
		$fell(DATA_BUSY_OE_O) |-> $past(DATA_BUSY_N_O))
		else $error("busy floated without negation");

endmodule : address_retry_data_grant

// file: verif/arb_snoop_model.sv
// Model of the bus arbiter and of a snooping master.
// Assumes go_i pulses one cycle; other inputs hold over a tenure.
`timescale 1ns/1ps
module arb_snoop_model (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic       rty_i,
	input  wire logic [1:0] dly_i,
	output logic [3:0]      cnt_o,
	output logic            ts_n_o,
	output logic            addr_ack_n_n_o,
	output logic            rty_n_o,
	output logic            gnt_n_o,
	output logic            ta_n_o
);
	initial cnt_o = 4'h0;
	always @(posedge clk_i) cnt_o <= go_i ? 4'h1 : cnt_o + {3'h0, cnt_o != 4'h0};
	assign ts_n_o = cnt_o != 4'h1;
	assign addr_ack_n_n_o = cnt_o != 4'h3 + {2'h0, dly_i};
	assign rty_n_o = !(rty_i && cnt_o > 4'h2 && cnt_o < 4'h5 + {2'h0, dly_i});
	assign gnt_n_o = cnt_o > 4'h0 && cnt_o < 4'h6;
	assign ta_n_o = !(cnt_o > 4'h7 && cnt_o < 4'hC);
endmodule : arb_snoop_model

// file: verif/tb_address_retry_data_grant.sv
// Self-checking bench for the retry and data grant block.
// Assumes the bench's pull-up on the shared retry wire.
`timescale 1ns/1ps
module tb_address_retry_data_grant;
	logic clk = 1'b0, nrst = 1'b0, go = 1'b0, ext = 1'b0, mst = 1'b0, pdis = 1'b0, wo_n = 1'b1;
	logic [1:0] dly = 2'h0;
	logic [3:0] cnt;
	logic [31:0] lfsr = 32'h8666;
	addr_retry_n_pkg::bus_in_s ctrl = '0;
	logic ts_n, addr_ack_n_n, ext_n, gnt_n, ta_n, rty_n, rty_oe, br_n, dbb_n, dbb_oe, abrt, trt, wf, bsy;
	int err_count = 0, cmp_count = 0, i, k, ca, ntr, blk;
	always #2.5 clk = ~clk;
	assign bsy = dbb_oe === 1'b1 && dbb_n === 1'b0;
	arb_snoop_model partner (.clk_i(clk), .go_i(go), .rty_i(ext), .dly_i(dly), .cnt_o(cnt),
		.ts_n_o(ts_n), .addr_ack_n_n_o(addr_ack_n_n), .rty_n_o(ext_n), .gnt_n_o(gnt_n), .ta_n_o(ta_n));
	address_retry_data_grant uut (.CLK_I(clk), .NRST_I(nrst), .CTRL_I(ctrl), .ADDR_MASTER_I(mst),
		.PRECHARGE_DIS_I(pdis), .TRANSFER_START_N_I(ts_n), .ADDR_ACK_N_I(addr_ack_n_n),
		.ADDR_RETRY_N_I(ext_n & (rty_oe ? rty_n : 1'b1)), .DATA_GRANT_N_I(gnt_n),
		.DATA_BUSY_N_I(dbb_oe ? dbb_n : 1'b1), .DATA_RETRY_N_I(!(blk == 1 && cnt == 4'h6)),
		.TRANSFER_ACK_N_I(ta_n), .WRITE_REORDER_N_I(wo_n), .ADDR_RETRY_N_O(rty_n),
		.ADDR_RETRY_OE_O(rty_oe), .BUS_REQUEST_N_O(br_n), .DATA_BUSY_N_O(dbb_n),
		.DATA_BUSY_OE_O(dbb_oe), .DATA_ABORT_O(abrt), .TENURE_RETRY_O(trt), .WRITE_FIRST_O(wf));
	function automatic logic [31:0] step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : step
	function automatic logic exp_oe(input int k, input int ca, input logic s, input logic p);
		return s && ((k > 3 && k < ca + 2) || (k == ca + 3 && !p));
	endfunction : exp_oe
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	initial begin
		#5000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		chk(rty_oe === 1'b0 && br_n === 1'b1 && dbb_oe === 1'b0, "reset outputs");
		for (i = 0; i < 24; i++) begin
			lfsr = step(lfsr);
			ctrl = addr_retry_n_pkg::bus_in_s'({1'b1, lfsr[0] | i < 2, lfsr[1], lfsr[2] & lfsr[3], 1'b1});
			pdis = i[0];
			mst = i[1] & !ctrl.snoop_hit;
			ext = lfsr[4];
			dly = {1'b0, lfsr[5]};
			blk = int'(lfsr[6]);
			wo_n = lfsr[7];
			ca = 3 + int'(dly);
			ntr = 0;
			go = 1'b1;
			for (k = 1; k < 16; k++) begin
				@(negedge clk);
				go = 1'b0;
				if (trt === 1'b1) ntr++;
				chk(abrt === 1'b0, "abort");
				chk(rty_oe === exp_oe(k, ca, ctrl.snoop_hit, pdis), "retry enable");
				if (rty_oe === 1'b1) chk(rty_n === (k > ca + 1), "retry level");
				if (k == ca + 2 && (ext || ctrl.need_push && ctrl.snoop_hit))
					chk(br_n === !(ctrl.snoop_hit && ctrl.need_push), "request");
				if (!ctrl.snoop_hit && !ext && k < 9)
					chk(bsy === (k >= 7 + blk && !ctrl.addr_only), "busy");
				if (!ctrl.snoop_hit && !ext && !ctrl.addr_only && k == 9)
					chk(wf === !wo_n, "reorder");
			end
			chk((ntr != 0) === (mst && ext), "tenure retry");
			@(negedge clk);
		end
		tally_and_finish();
	end
endmodule : tb_address_retry_data_grant
